//--- rtl/dps_pkg.sv
/*
 * dps_pkg: constants, state encoding and carrier structs for the drive power
 * state register bank. Assumes nothing beyond a SystemVerilog compiler.
 */
package dps_pkg;

	// object indices of the register bank
	localparam logic [15:0] IDX_SERIAL_NUMBER = 16'h4040;
	localparam logic [15:0] IDX_DEVICE_ID     = 16'h4041;
	localparam logic [15:0] IDX_LAST_ERROR    = 16'h603f;
	localparam logic [15:0] IDX_COMMAND       = 16'h6040;
	localparam logic [15:0] IDX_REPORT        = 16'h6041;
	localparam logic [15:0] IDX_VEL_SETPOINT  = 16'h6042;
	localparam logic [15:0] IDX_VEL_COMMAND   = 16'h6043;

	// reset values
	localparam logic [15:0] RST_COMMAND      = 16'h0000;
	localparam logic [15:0] RST_REPORT       = 16'h0000;
	localparam logic [15:0] RST_LAST_ERROR   = 16'h0000;
	localparam logic [15:0] RST_VEL_SETPOINT = 16'h00c8;
	localparam logic [15:0] RST_VEL_COMMAND  = 16'h0000;

	// command word bit positions
	localparam int CMD_SWITCH_ON  = 0;
	localparam int CMD_VOLTAGE    = 1;
	localparam int CMD_FAST_STOP  = 2;
	localparam int CMD_OP_ENABLE  = 3;
	localparam int CMD_MODE_LO    = 4;
	localparam int CMD_MODE_HI    = 6;
	localparam int CMD_FAULT_CLR  = 7;
	localparam int CMD_HALT       = 8;
	localparam int CMD_MODE_EXTRA = 9;

	// report word bit positions
	localparam int REP_FAULT      = 3;
	localparam int REP_VOLTAGE    = 4;
	localparam int REP_FAST_STOP  = 5;
	localparam int REP_DISABLED   = 6;
	localparam int REP_WARNING    = 7;
	localparam int REP_SYNC       = 8;
	localparam int REP_REMOTE     = 9;
	localparam int REP_TARGET     = 10;
	localparam int REP_LIMIT      = 11;
	localparam int REP_MODE_LO    = 12;
	localparam int REP_MODE_HI    = 13;
	localparam int REP_CLOSED     = 15;

	// operating mode codes for which halt is honoured
	localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
	localparam logic [7:0] MODE_VELOCITY    = 8'h02;
	localparam logic [7:0] MODE_PROFILE_VEL = 8'h03;
	localparam logic [7:0] MODE_PROFILE_TRQ = 8'h04;
	localparam logic [7:0] MODE_INTERP_POS  = 8'h07;

	typedef enum logic [2:0] {
		ST_NOT_READY   = 3'b000,
		ST_DISABLED    = 3'b001,
		ST_READY       = 3'b010,
		ST_SWITCHED_ON = 3'b011,
		ST_ENABLED     = 3'b100,
		ST_QUICK_STOP  = 3'b101,
		ST_FAULT_REACT = 3'b110,
		ST_FAULT       = 3'b111
	} dps_state_t;

	// object access request from the fieldbus side
	typedef struct packed {
		logic [15:0] index;
		logic        wr;
		logic        rd;
		logic [15:0] wdata;
	} dps_req_t;

	// drive-side status inputs
	typedef struct packed {
		logic        fault_detect;
		logic        fault_clearable;
		logic        fault_react_done;
		logic        voltage_present;
		logic        warning;
		logic        target_reached;
		logic        closed_loop;
		logic [1:0]  mode_status;
		logic [7:0]  op_mode;
		logic [15:0] vel_min_amount;
		logic [15:0] vel_max_amount;
	} dps_drive_t;

	typedef struct packed {
		dps_state_t  state;
		logic [15:0] command;
		logic [15:0] report;
		logic [15:0] last_error;
		logic [15:0] vel_setpoint;
		logic [15:0] vel_command;
		logic [2:0]  sync_pipe;
		logic        sync_ok;
		logic        halt;
		logic [3:0]  mode_bits;
		logic [15:0] rdata;
		logic        ack;
		logic        err;
	} dps_regs_t;

endpackage

//--- rtl/dps_power_state_regs.sv
/*
 * dps_power_state_regs: command/report word bank with the drive power state
 * machine, last error code and velocity setpoint/command objects.
 * Assumes the fieldbus stack presents one object access per strobe on
 * clk_sys, and that drive-side status inputs come from logic on clk_sys;
 * only the fieldbus sync indication arrives from outside and is synchronised.
 */
`timescale 1ns/10ps

// Function
// [R1] 16-bit read/write command word, reset to zero, steering the power state machine
// [R2] command bit 0 set requests the switched-on state
// [R3] command bit 1 set requests the voltage-enable transition
// [R4] command bit 2 cleared (active low) sends the machine to quick stop from operation enabled, and to disabled from ready or switched on
// [R5] command bit 3 set requests the operation-enabled state
// [R6] command bit 7 clears a pending fault only when the fault permits it
// [R7] command bit 8 halts motion only in five listed operating modes
// [R8] command bits 4-6, 9 and report bits 12-13 are mode dependent
// [R9] 16-bit read-only report word, reset zero, shows state and flags
// [R10] report bits 0,1,2 show ready, switched on, operation enabled
// [R11] report bit 5 reads zero while quick stop is active
// [R12] report bit 6 reads one in the switched-on-disabled state
// [R13] report bit 8 reads one while synchronised with the fieldbus
// [R14] report bit 9, remote, always reads one
// [R15] report bit 15 reads one only when enabled with closed loop active
// [R16] report bits 6, 5, 3..0 encode the eight states as tabled
// [R17] 16-bit read-only last error register, reset zero
// [R18] last error equals low sixteen bits of newest error history entry
// [R19] signed 16-bit setpoint register, reset 00c8, velocity-mode target
// [R20] signed 16-bit read-only command actually given to the controller
// [R21] read-only device identifier and serial number objects
// [R22] setpoint outside min/max amount is clamped and report bit 11 set
// [R23] state moves only between adjacent states, evaluated on each command write; not-ready exit, fault entry and fault reaction exit need no write
module dps_power_state_regs #(
	parameter int          WORD_W    = 16,
	parameter logic [15:0] SERIAL_ID = 16'h0001, // arbitrary value
	parameter logic [15:0] DEVICE_ID = 16'h0002  // arbitrary value
) (
	// clock, reset, enable
	input  wire logic                clk_sys,
	input  wire logic                resetn,
	input  wire logic                clk_en,
	// object access
	input  wire dps_pkg::dps_req_t   od_req,
	output logic [15:0]              od_rdata,
	output logic                     od_ack,
	output logic                     od_err,
	// drive side
	input  wire dps_pkg::dps_drive_t drive,
	input  wire logic                sync_pin,
	input  wire logic                err_push,
	input  wire logic [31:0]         err_newest,
	// to the controller
	output dps_pkg::dps_state_t      power_state,
	output logic                     halt,
	output logic [3:0]               mode_bits,
	output logic [15:0]              vel_command
);

	if (WORD_W != 16) begin : g_width_check
		$error("dps_power_state_regs serves 16-bit words only");
	end

	dps_pkg::dps_regs_t r;
	dps_pkg::dps_regs_t next_r;

	logic        cmd_wr;
	logic [15:0] cmd;
	logic        halt_mode;
	logic [16:0] sp_mag;
	logic [16:0] cl_mag;
	logic [16:0] min_mag;
	logic [16:0] max_mag;
	logic [16:0] cl_signed;
	logic        clamp;
	logic        mapped;
	logic        writable;

	always_comb begin
		next_r = r;
		cmd_wr = od_req.wr && (od_req.index == dps_pkg::IDX_COMMAND);
		cmd = cmd_wr ? od_req.wdata : r.command;
		mapped = 1'b0;
		writable = 1'b0;
		next_r.ack = 1'b0;
		next_r.err = 1'b0;

		// sync indication: count a change once stages two and three agree
		next_r.sync_pipe = {r.sync_pipe[1:0], sync_pin};
		if (r.sync_pipe[1] == r.sync_pipe[2]) begin
			next_r.sync_ok = r.sync_pipe[2]; // see [R13]
		end

		// register writes
		if (cmd_wr) begin
			next_r.command = od_req.wdata; // see [R1]
		end
		if (od_req.wr && od_req.index == dps_pkg::IDX_VEL_SETPOINT) begin
			next_r.vel_setpoint = od_req.wdata; // see [R19]
		end
		if (err_push) begin
			next_r.last_error = err_newest[15:0]; // see [R17] see [R18]
		end

		// state machine, stepped on command writes except automatic moves
		case (r.state)
			dps_pkg::ST_NOT_READY: begin
				next_r.state = dps_pkg::ST_DISABLED;
			end
			dps_pkg::ST_DISABLED: begin
				// shutdown: voltage and fast-stop set, switch-on clear
				if (cmd_wr && cmd[dps_pkg::CMD_VOLTAGE] && cmd[dps_pkg::CMD_FAST_STOP]
						&& !cmd[dps_pkg::CMD_SWITCH_ON]) begin
					next_r.state = dps_pkg::ST_READY; // see [R3] see [R23]
				end
			end
			dps_pkg::ST_READY: begin
				if (cmd_wr) begin
					if (!cmd[dps_pkg::CMD_VOLTAGE] || !cmd[dps_pkg::CMD_FAST_STOP]) begin
						next_r.state = dps_pkg::ST_DISABLED; // see [R4]
					end else if (cmd[dps_pkg::CMD_SWITCH_ON]) begin
						next_r.state = dps_pkg::ST_SWITCHED_ON; // see [R2] see [R23]
					end
				end
			end
			dps_pkg::ST_SWITCHED_ON: begin
				if (cmd_wr) begin
					if (!cmd[dps_pkg::CMD_VOLTAGE] || !cmd[dps_pkg::CMD_FAST_STOP]) begin
						next_r.state = dps_pkg::ST_DISABLED; // see [R4]
					end else if (!cmd[dps_pkg::CMD_SWITCH_ON]) begin
						next_r.state = dps_pkg::ST_READY;
					end else if (cmd[dps_pkg::CMD_OP_ENABLE]) begin
						next_r.state = dps_pkg::ST_ENABLED; // see [R5] see [R23]
					end
				end
			end
			dps_pkg::ST_ENABLED: begin
				if (cmd_wr) begin
					if (!cmd[dps_pkg::CMD_VOLTAGE]) begin
						next_r.state = dps_pkg::ST_DISABLED;
					end else if (!cmd[dps_pkg::CMD_FAST_STOP]) begin
						next_r.state = dps_pkg::ST_QUICK_STOP; // see [R4]
					end else if (!cmd[dps_pkg::CMD_SWITCH_ON]) begin
						next_r.state = dps_pkg::ST_READY;
					end else if (!cmd[dps_pkg::CMD_OP_ENABLE]) begin
						next_r.state = dps_pkg::ST_SWITCHED_ON;
					end
				end
			end
			dps_pkg::ST_QUICK_STOP: begin
				// leaving quick stop only via voltage disable or a detected fault
				if (cmd_wr && !cmd[dps_pkg::CMD_VOLTAGE]) begin
					next_r.state = dps_pkg::ST_DISABLED; // see [R23]
				end
			end
			dps_pkg::ST_FAULT_REACT: begin
				if (drive.fault_react_done) begin
					next_r.state = dps_pkg::ST_FAULT;
				end
			end
			dps_pkg::ST_FAULT: begin
				// rising edge of the clear bit, and the fault must allow it
				if (cmd_wr && cmd[dps_pkg::CMD_FAULT_CLR] && !r.command[dps_pkg::CMD_FAULT_CLR]
						&& drive.fault_clearable && !drive.fault_detect) begin
					next_r.state = dps_pkg::ST_DISABLED; // see [R6]
				end
			end
			default: begin
				next_r.state = dps_pkg::ST_NOT_READY;
			end
		endcase

		// a fault overrides any command in the same cycle
		if (drive.fault_detect && r.state != dps_pkg::ST_FAULT
				&& r.state != dps_pkg::ST_FAULT_REACT) begin
			next_r.state = dps_pkg::ST_FAULT_REACT;
		end

		// halt honoured only in the listed modes
		halt_mode = (drive.op_mode == dps_pkg::MODE_PROFILE_POS)
			|| (drive.op_mode == dps_pkg::MODE_VELOCITY)
			|| (drive.op_mode == dps_pkg::MODE_PROFILE_VEL)
			|| (drive.op_mode == dps_pkg::MODE_PROFILE_TRQ)
			|| (drive.op_mode == dps_pkg::MODE_INTERP_POS);
		next_r.halt = next_r.command[dps_pkg::CMD_HALT] && halt_mode; // see [R7]
		next_r.mode_bits = {next_r.command[dps_pkg::CMD_MODE_EXTRA],
			next_r.command[dps_pkg::CMD_MODE_HI:dps_pkg::CMD_MODE_LO]}; // see [R8]

		// clamp the setpoint magnitude; min above 32767 wraps, user must keep it sane
		sp_mag = next_r.vel_setpoint[15] ? (17'h0_0000 - {1'b1, next_r.vel_setpoint})
			: {1'b0, next_r.vel_setpoint};
		min_mag = {1'b0, drive.vel_min_amount};
		max_mag = {1'b0, drive.vel_max_amount};
		clamp = 1'b0;
		cl_mag = sp_mag;
		if (sp_mag < min_mag) begin
			cl_mag = min_mag; // see [R22]
			clamp = 1'b1;
		end else if (sp_mag > max_mag) begin
			cl_mag = max_mag; // see [R22]
			clamp = 1'b1;
		end
		cl_signed = next_r.vel_setpoint[15] ? (17'h0_0000 - cl_mag) : cl_mag;
		if (next_r.state == dps_pkg::ST_ENABLED && drive.op_mode == dps_pkg::MODE_VELOCITY
				&& !next_r.halt) begin
			next_r.vel_command = cl_signed[15:0]; // see [R20]
		end else begin
			next_r.vel_command = dps_pkg::RST_VEL_COMMAND;
		end

		// report word follows the state being entered
		next_r.report = 16'h0000;
		case (next_r.state)
			dps_pkg::ST_NOT_READY:   next_r.report[6:0] = 7'b000_0000;
			dps_pkg::ST_DISABLED:    next_r.report[6:0] = 7'b100_0000; // see [R12]
			dps_pkg::ST_READY:       next_r.report[6:0] = 7'b010_0001;
			dps_pkg::ST_SWITCHED_ON: next_r.report[6:0] = 7'b010_0011;
			dps_pkg::ST_ENABLED:     next_r.report[6:0] = 7'b010_0111; // see [R10]
			dps_pkg::ST_QUICK_STOP:  next_r.report[6:0] = 7'b000_0111; // see [R11]
			dps_pkg::ST_FAULT_REACT: next_r.report[6:0] = 7'b000_1111;
			dps_pkg::ST_FAULT:       next_r.report[6:0] = 7'b000_1000; // see [R16]
			default:                 next_r.report[6:0] = 7'b000_0000;
		endcase
		next_r.report[dps_pkg::REP_VOLTAGE] = drive.voltage_present;
		next_r.report[dps_pkg::REP_WARNING] = drive.warning;
		next_r.report[dps_pkg::REP_SYNC] = next_r.sync_ok; // see [R13]
		next_r.report[dps_pkg::REP_REMOTE] = 1'b1; // see [R14]
		next_r.report[dps_pkg::REP_TARGET] = drive.target_reached;
		next_r.report[dps_pkg::REP_LIMIT] = clamp; // see [R22]
		next_r.report[dps_pkg::REP_MODE_HI:dps_pkg::REP_MODE_LO] = drive.mode_status; // see [R8]
		next_r.report[dps_pkg::REP_CLOSED] = (next_r.state == dps_pkg::ST_ENABLED)
			&& drive.closed_loop; // see [R15]

		// object read and access answer
		case (od_req.index)
			dps_pkg::IDX_SERIAL_NUMBER: begin
				next_r.rdata = SERIAL_ID; // see [R21]
				mapped = 1'b1;
			end
			dps_pkg::IDX_DEVICE_ID: begin
				next_r.rdata = DEVICE_ID; // see [R21]
				mapped = 1'b1;
			end
			dps_pkg::IDX_LAST_ERROR: begin
				next_r.rdata = r.last_error;
				mapped = 1'b1;
			end
			dps_pkg::IDX_COMMAND: begin
				next_r.rdata = r.command;
				mapped = 1'b1;
				writable = 1'b1;
			end
			dps_pkg::IDX_REPORT: begin
				next_r.rdata = r.report; // see [R9]
				mapped = 1'b1;
			end
			dps_pkg::IDX_VEL_SETPOINT: begin
				next_r.rdata = r.vel_setpoint;
				mapped = 1'b1;
				writable = 1'b1;
			end
			dps_pkg::IDX_VEL_COMMAND: begin
				next_r.rdata = r.vel_command;
				mapped = 1'b1;
			end
			default: begin
				next_r.rdata = 16'h0000;
			end
		endcase
		if (!od_req.rd) begin
			next_r.rdata = r.rdata;
		end
		if (od_req.rd || od_req.wr) begin
			next_r.ack = 1'b1;
			next_r.err = !mapped || (od_req.wr && !writable);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			r.state <= dps_pkg::ST_NOT_READY;
			r.command <= dps_pkg::RST_COMMAND;
			r.report <= dps_pkg::RST_REPORT;
			r.last_error <= dps_pkg::RST_LAST_ERROR;
			r.vel_setpoint <= dps_pkg::RST_VEL_SETPOINT;
			r.vel_command <= dps_pkg::RST_VEL_COMMAND;
			r.sync_pipe <= 3'h0;
			r.sync_ok <= 1'b0;
			r.halt <= 1'b0;
			r.mode_bits <= 4'h0;
			r.rdata <= 16'h0000;
			r.ack <= 1'b0;
			r.err <= 1'b0;
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	assign od_rdata = r.rdata;
	assign od_ack = r.ack;
	assign od_err = r.err;
	assign power_state = r.state;
	assign halt = r.halt;
	assign mode_bits = r.mode_bits;
	assign vel_command = r.vel_command;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_shutdown_wr;
		clk_en && r.state == dps_pkg::ST_DISABLED && cmd_wr && od_req.wdata[2:0] == 3'b110
			&& !drive.fault_detect;
	endsequence

	sequence s_fault_clear_wr;
		clk_en && r.state == dps_pkg::ST_FAULT && cmd_wr && od_req.wdata[7]
			&& !r.command[7] && drive.fault_clearable && !drive.fault_detect;
	endsequence

	a_shutdown_step: assert property (s_shutdown_wr |=> r.state == dps_pkg::ST_READY) // see [R3]
		else $error("shutdown write did not reach ready");
	a_fault_clear: assert property (s_fault_clear_wr |=> r.state == dps_pkg::ST_DISABLED) // see [R6]
		else $error("permitted fault clear did not leave fault");
	a_fault_entry: assert property (clk_en && drive.fault_detect // see [R23]
		&& r.state inside {dps_pkg::ST_ENABLED, dps_pkg::ST_READY}
		|=> r.state == dps_pkg::ST_FAULT_REACT)
		else $error("fault did not start fault reaction");
	a_remote_one: assert property (clk_en |=> r.report[9]) // see [R14]
		else $error("remote flag not set");
	a_closed_loop: assert property (r.report[15] |-> r.state == dps_pkg::ST_ENABLED) // see [R15]
		else $error("closed loop flag outside operation enabled");
	a_quick_stop: assert property (clk_en ##1 r.state == dps_pkg::ST_QUICK_STOP // see [R11]
		|-> !r.report[5] && r.report[2:0] == 3'b111)
		else $error("quick stop code wrong");
	a_fault_code: assert property (clk_en ##1 r.state == dps_pkg::ST_FAULT // see [R16]
		|-> r.report[3:0] == 4'b1000 && !r.report[6])
		else $error("fault code wrong");
	a_no_skip: assert property ($past(r.state) == dps_pkg::ST_DISABLED // see [R23]
		|-> r.state inside {dps_pkg::ST_DISABLED, dps_pkg::ST_READY, dps_pkg::ST_FAULT_REACT})
		else $error("state skipped a step");
	a_error_latch: assert property (clk_en && err_push |=> r.last_error == $past(err_newest[15:0])) // see [R18]
		else $error("last error not the newest entry");
	a_halt_mode: assert property (r.halt |-> r.command[8]) // see [R7]
		else $error("halt without halt command");
	a_read_report: assert property (clk_en && od_req.rd && od_req.index == dps_pkg::IDX_REPORT
		|=> od_ack && !od_err && od_rdata == $past(r.report)) // see [R9]
		else $error("report read answer wrong");

endmodule

//--- testbench/dps_fb_master.sv
/*
 * dps_fb_master: fieldbus master model, one object access per call.
 * Assumes the bank takes a request on one enabled rising edge and answers next cycle.
 */
`timescale 1ns/10ps
module dps_fb_master (
	// clock
	input  wire logic         clk_sys,
	// object access
	output dps_pkg::dps_req_t od_req,
	input  wire logic [15:0]  od_rdata,
	input  wire logic         od_ack,
	input  wire logic         od_err
);
	initial od_req = '0;

	// held across exactly one rising edge, answer taken at the next falling edge
	task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
		output logic [15:0] rd, output logic ack, output logic err);
		@(negedge clk_sys);
		od_req.index = idx;
		od_req.wr    = wr;
		od_req.rd    = ~wr;
		od_req.wdata = wr ? wd : ~wd;
		@(negedge clk_sys);
		ack          = od_ack;
		err          = od_err;
		rd           = od_rdata;
		od_req.wr    = 1'b0;
		od_req.rd    = 1'b0;
		// stale data flips so a late sampler cannot pass by luck
		od_req.wdata = ~od_req.wdata;
	endtask
endmodule

//--- testbench/test_drive_power_state_regs.sv
/*
 * test_drive_power_state_regs: self-checking bench with a reference model.
 * Assumes the fieldbus master model and the bank share clk_sys.
 */
`timescale 1ns/10ps
module test_drive_power_state_regs;
	logic                clk_sys;
	logic                resetn;
	logic                clk_en;
	dps_pkg::dps_req_t   od_req;
	logic [15:0]         od_rdata;
	logic                od_ack;
	logic                od_err;
	dps_pkg::dps_drive_t drv;
	logic                sync_pin;
	logic                err_push;
	logic [31:0]         err_newest;
	dps_pkg::dps_state_t power_state;
	logic                halt;
	logic [3:0]          mode_bits;
	logic [15:0]         vel_command;
	int                  n_mismatch;
	int                  compares;
	int                  cycles;
	int                  v;
	dps_pkg::dps_state_t st;
	logic [15:0]         cmd;
	logic [15:0]         sp;
	logic [15:0]         lasterr;
	logic                sync_m;
	logic [15:0]         stb [8] = '{16'h0000, 16'h0040, 16'h0021, 16'h0023,
	                                 16'h0027, 16'h0007, 16'h000f, 16'h0008};
	logic [15:0]         ro [5]  = '{16'h4040, 16'h4041, 16'h603f, 16'h6041, 16'h6043};
	logic [15:0]         walk [7] = '{16'h0006, 16'h0007, 16'h000f, 16'h0007,
	                                  16'h0006, 16'h000f, 16'h027f};
	logic [15:0]         edge_sp [4] = '{16'h0031, 16'h0032, 16'h07d0, 16'hf82f};

	dps_power_state_regs DUT (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
		.od_req(od_req), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err),
		.drive(drv), .sync_pin(sync_pin), .err_push(err_push), .err_newest(err_newest),
		.power_state(power_state), .halt(halt), .mode_bits(mode_bits),
		.vel_command(vel_command));
	dps_fb_master u_master (.clk_sys(clk_sys), .od_req(od_req), .od_rdata(od_rdata),
		.od_ack(od_ack), .od_err(od_err));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	function automatic int mag();
		v = $signed(sp);
		return (v < 0) ? -v : v;
	endfunction

	function automatic logic exp_halt();
		return cmd[8] && (drv.op_mode inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h07});
	endfunction

	function automatic logic [15:0] exp_vel();
		int m;
		m = mag();
		if (st != dps_pkg::ST_ENABLED || drv.op_mode != 8'h02 || exp_halt())
			return 16'h0000;
		if (m < drv.vel_min_amount)
			m = drv.vel_min_amount;
		if (m > drv.vel_max_amount)
			m = drv.vel_max_amount;
		return 16'(sp[15] ? -m : m);
	endfunction

	function automatic logic [15:0] exp_report();
		logic [15:0] r;
		r       = stb[st] | 16'h0200;
		r[4]    = drv.voltage_present;
		r[7]    = drv.warning;
		r[8]    = sync_m;
		r[10]   = drv.target_reached;
		r[11]   = mag() < drv.vel_min_amount || mag() > drv.vel_max_amount;
		r[13:12] = drv.mode_status;
		r[15]   = drv.closed_loop && st == dps_pkg::ST_ENABLED;
		return r;
	endfunction

	// model of the power state steps taken on a command write
	function automatic dps_pkg::dps_state_t nxt(input logic [15:0] w);
		case (st)
			dps_pkg::ST_DISABLED: if (w[2:0] == 3'b110) return dps_pkg::ST_READY;
			dps_pkg::ST_READY: if (!w[1] || !w[2]) return dps_pkg::ST_DISABLED;
				else if (w[0]) return dps_pkg::ST_SWITCHED_ON;
			dps_pkg::ST_SWITCHED_ON: if (!w[1] || !w[2]) return dps_pkg::ST_DISABLED;
				else if (w[3:0] == 4'b1111) return dps_pkg::ST_ENABLED;
				else if (!w[0]) return dps_pkg::ST_READY;
			dps_pkg::ST_ENABLED: if (!w[1]) return dps_pkg::ST_DISABLED;
				else if (!w[2]) return dps_pkg::ST_QUICK_STOP;
				else if (w[3:0] == 4'b0111) return dps_pkg::ST_SWITCHED_ON;
				else if (!w[0]) return dps_pkg::ST_READY;
			dps_pkg::ST_QUICK_STOP: if (!w[1]) return dps_pkg::ST_DISABLED;
			dps_pkg::ST_FAULT: if (w[7] && !cmd[7] && drv.fault_clearable && !drv.fault_detect)
				return dps_pkg::ST_DISABLED;
			default: return st;
		endcase
		return st;
	endfunction

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// ae: expected {ack, err}; 2'b00 means the request must not be taken
	task automatic acc(input logic wr, input logic [15:0] idx, input logic [15:0] d,
		input logic [1:0] ae, input logic [15:0] exp, input logic [15:0] mask);
		logic [15:0] r;
		logic        a;
		logic        e;
		u_master.access(wr, idx, d, r, a, e);
		chk("ack and err", 16'(ae), {14'h0000, a, e});
		if (!wr && ae == 2'b10)
			chk("read data", exp & mask, r & mask);
		if (wr && ae == 2'b10 && idx == 16'h6040) begin
			st  = nxt(d);
			cmd = d;
		end
		if (wr && ae == 2'b10 && idx == 16'h6042)
			sp = d;
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic chk_out();
		chk("state", 16'(st), 16'(power_state));
		chk("halt", 16'(exp_halt()), 16'(halt));
		chk("mode bits", {12'h000, cmd[9], cmd[6:4]}, 16'(mode_bits));
		chk("velocity", exp_vel(), vel_command);
		acc(1'b0, 16'h6041, 16'h0000, 2'b10, exp_report(),
			(st >= 2 && st <= 5) ? 16'hffff : 16'hffdf);
	endtask

	task automatic do_reset();
		resetn = 1'b0;
		settle(2);
		chk("state in reset", 16'h0000, 16'(power_state));
		resetn  = 1'b1;
		st      = dps_pkg::ST_DISABLED;
		cmd     = 16'h0000;
		sp      = 16'h00c8;
		lasterr = 16'h0000;
		// sync pipe restarts empty; let it refill before the report is read
		settle(6);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	initial begin
		void'($urandom(15825));
		{resetn, sync_pin, err_push, err_newest, sync_m} = '0;
		clk_en = 1'b1;
		drv = '0;
		drv.vel_min_amount = 16'h0032;
		drv.vel_max_amount = 16'h07d0;
		do_reset();
		acc(1'b0, 16'h603f, 16'h0000, 2'b10, 16'h0000, 16'hffff);
		acc(1'b0, 16'h6040, 16'h0000, 2'b10, 16'h0000, 16'hffff);
		acc(1'b0, 16'h6042, 16'h0000, 2'b10, 16'h00c8, 16'hffff);
		acc(1'b0, 16'h6043, 16'h0000, 2'b10, 16'h0000, 16'hffff);
		acc(1'b0, 16'h4040, 16'h0000, 2'b10, 16'h0001, 16'hffff);
		acc(1'b0, 16'h4041, 16'h0000, 2'b10, 16'h0002, 16'hffff);
		acc(1'b0, 16'h1234, 16'h0000, 2'b11, 16'h0000, 16'h0000);
		foreach (ro[i])
			acc(1'b1, ro[i], 16'hffff, 2'b11, 16'h0000, 16'h0000);
		chk_out();
		drv.voltage_present = 1'b1;
		drv.closed_loop = 1'b1;
		drv.op_mode = 8'h02;
		{drv.warning, drv.target_reached, drv.mode_status} = 4'($urandom);
		sync_pin = 1'b1;
		sync_m = 1'b1;
		settle(6);
		chk_out();
		foreach (walk[i]) begin
			acc(1'b1, 16'h6040, walk[i], 2'b10, 16'h0000, 16'h0000);
			chk_out();
		end
		for (int i = 0; i < 10; i++) begin
			v = (i < 4) ? edge_sp[i] : int'($urandom_range(4000)) - 2000;
			acc(1'b1, 16'h6042, 16'(v), 2'b10, 16'h0000, 16'h0000);
			chk_out();
		end
		acc(1'b1, 16'h6040, 16'h010f, 2'b10, 16'h0000, 16'h0000);
		for (int m = 1; m < 9; m++) begin
			drv.op_mode = 8'(m);
			settle(2);
			chk_out();
		end
		drv.op_mode = 8'h02;
		acc(1'b1, 16'h6040, 16'h000b, 2'b10, 16'h0000, 16'h0000);
		chk_out();
		acc(1'b1, 16'h6040, 16'h0000, 2'b10, 16'h0000, 16'h0000);
		chk_out();
		acc(1'b1, 16'h6040, 16'h0006, 2'b10, 16'h0000, 16'h0000);
		drv.fault_detect = 1'b1;
		st = dps_pkg::ST_FAULT_REACT;
		settle(2);
		chk_out();
		drv.fault_detect = 1'b0;
		drv.fault_react_done = 1'b1;
		st = dps_pkg::ST_FAULT;
		settle(2);
		chk_out();
		acc(1'b1, 16'h6040, 16'h0080, 2'b10, 16'h0000, 16'h0000);
		chk_out();
		acc(1'b1, 16'h6040, 16'h0000, 2'b10, 16'h0000, 16'h0000);
		drv.fault_clearable = 1'b1;
		acc(1'b1, 16'h6040, 16'h0080, 2'b10, 16'h0000, 16'h0000);
		chk_out();
		drv.fault_react_done = 1'b0;
		err_newest = $urandom;
		err_push = 1'b1;
		lasterr = err_newest[15:0];
		settle(1);
		err_push = 1'b0;
		acc(1'b0, 16'h603f, 16'h0000, 2'b10, lasterr, 16'hffff);
		// a frozen bank holds its last ack, so let one enabled edge clear it first
		settle(1);
		clk_en = 1'b0;
		acc(1'b1, 16'h6042, 16'h0123, 2'b00, 16'h0000, 16'h0000);
		clk_en = 1'b1;
		acc(1'b0, 16'h6042, 16'h0000, 2'b10, sp, 16'hffff);
		do_reset();
		chk_out();
		acc(1'b0, 16'h6042, 16'h0000, 2'b10, 16'h00c8, 16'hffff);
		end_of_test();
	end
endmodule
